// ===== rtl/gpio_pad_bank.sv
// General purpose pad bank with alternate pad functions
// Summary of operation
// - Each pad: input, output or alternate function
// - Input pad reads back sampled pad level
// - Output pad takes writes, reads driven level
// - Alternate pad ignores host reads and writes
// - Reset to input; powered off drives low, except alarm pad in alternate mode
// - Output pads drive push-pull, both levels
// - Mute pad high while no audio sent
// - Amplifier enable only while voice present
// - Transmit pad follows radio transmit state
// - Alarm rises at start, held until clear
// - Tone pad drives requested square wave
// - Power saving switches off both square waves, amplifier enable and call key
// - Sleep request or receive low enters saving
// - Vibrator pad drives square wave like tone
// - Call key press with earphone places call
// - Active pad high only after boot done
`timescale 1ns/1ns
module gpio_pad_bank #(
   parameter int NUM_PADS = gpio_pkg::NUM_PADS_DEF
) (
   // Clock and reset
   input  wire logic                           i_clk,
   input  wire logic                           i_rst_b,
   // Host configuration and access
   input  wire logic [gpio_pkg::MODE_W*NUM_PADS-1:0] i_pad_mode,
   input  wire logic [NUM_PADS-1:0]            i_wr_mask,
   input  wire logic [NUM_PADS-1:0]            i_wr_level,
   output logic      [NUM_PADS-1:0]            o_pad_value,
   // Pads
   input  wire logic [NUM_PADS-1:0]            i_pad_in,
   output logic      [NUM_PADS-1:0]            o_pad_out,
   output logic      [NUM_PADS-1:0]            o_pad_oe,
   // Module state from firmware
   input  wire logic                           i_power_on,
   input  wire logic                           i_boot_done,
   input  wire logic                           i_audio_active,
   input  wire logic                           i_voice_present,
   input  wire logic                           i_radio_tx,
   input  wire logic                           i_earphone_in,
   // Alarm events
   input  wire logic                           i_alarm_start,
   input  wire logic                           i_alarm_clear,
   // Square wave requests, tone first, vibrator second
   input  wire logic [gpio_pkg::NUM_WAVES-1:0] i_wave_on,
   input  wire logic [gpio_pkg::HALF_W-1:0]    i_tone_half,
   input  wire logic [gpio_pkg::HALF_W-1:0]    i_vibe_half,
   // Serial receive line (pin)
   input  wire logic                           i_uart_rx,
   // Results to firmware
   output logic                                o_power_save,
   output logic                                o_call_press
);
   import gpio_pkg::*;

   if (NUM_PADS < PAD_MIN) begin : g_bad_pads
      $error("NUM_PADS too small for the alternate pad map");
   end
   if (TICK_CYCLES >= (1 << TICK_W)) begin : g_bad_tick
      $error("TICK_W too narrow for the tick divider");
   end

   typedef struct packed {
      logic [NUM_PADS-1:0]               out_level;
      logic [NUM_PADS-1:0]               pad_out;
      logic [NUM_PADS-1:0]               pad_oe;
      logic [NUM_PADS-1:0]               pad_value;
      logic                              alarm;
      logic [TICK_W-1:0]                 tick_cnt;
      logic                              tick;
      logic [NUM_WAVES-1:0][HALF_W-1:0]  wave_cnt;
      logic [NUM_WAVES-1:0]              wave_lvl;
      logic                              power_save;
      logic                              key_prev;
      logic                              call_press;
   } state_t;

   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

   state_t              st;
   state_t              next_st;
   logic [NUM_PADS:0]   sync_raw;
   logic [NUM_PADS:0]   sync_out;
   logic [NUM_PADS-1:0] pin_s;
   logic                rx_s;
   logic [NUM_PADS-1:0] alt_val;
   logic [NUM_PADS-1:0] alt_drv;
   logic                sleep_req;
   logic [HALF_W-1:0]   half [NUM_WAVES];
   mode_t               pmode [NUM_PADS];

   // Pads and receive line all cross through one synchroniser
   assign sync_raw = {i_uart_rx, i_pad_in};

   pin_sync #(
      .W        (NUM_PADS + 1)
   ) u_sync (
      .i_clk    (i_clk),
      .i_rst_b  (i_rst_b),
      .i_async  (sync_raw),
      .o_stable (sync_out)
   );

   assign pin_s = sync_out[NUM_PADS-1:0];
   assign rx_s  = sync_out[NUM_PADS];

   always_comb begin
      for (int i = 0; i < NUM_PADS; i++) begin
         pmode[i] = mode_t'(i_pad_mode[MODE_W*i +: MODE_W]);
      end
      half[WAVE_TONE] = i_tone_half;
      half[WAVE_VIBE] = i_vibe_half;
   end

   // Host sleep request is active low; receive low acts the same
   assign sleep_req = ((pmode[PAD_SLEEP] == MODE_ALT) && !pin_s[PAD_SLEEP])
                      || !rx_s;

   // Values and drive flags of the alternate functions
   always_comb begin
      alt_val            = '0;
      alt_drv            = '0;
      alt_drv[PAD_MUTE]  = 1'b1;
      alt_val[PAD_MUTE]  = !i_audio_active;
      alt_drv[PAD_AMP]   = 1'b1;
      alt_val[PAD_AMP]   = i_voice_present && !st.power_save;
      alt_drv[PAD_TX]    = 1'b1;
      alt_val[PAD_TX]    = i_radio_tx;
      alt_drv[PAD_ALARM] = 1'b1;
      alt_val[PAD_ALARM] = st.alarm;
      alt_drv[PAD_TONE]  = 1'b1;
      alt_val[PAD_TONE]  = st.wave_lvl[WAVE_TONE];
      alt_drv[PAD_VIBE]  = 1'b1;
      alt_val[PAD_VIBE]  = st.wave_lvl[WAVE_VIBE];
      alt_drv[PAD_BOOT]  = 1'b1;
      alt_val[PAD_BOOT]  = i_boot_done;
   end

   always_comb begin
      next_st      = st;
      next_st.tick = 1'b0;

      // Tick divider paces both square waves
      if (st.tick_cnt == TICK_LAST) begin
         next_st.tick_cnt = '0;
         next_st.tick     = 1'b1;
      end else begin
         next_st.tick_cnt = st.tick_cnt + TICK_W'(1);
      end

      // Start wins over a clear in the same cycle
      if (i_alarm_start) begin
         next_st.alarm = 1'b1;
      end else if (i_alarm_clear) begin
         next_st.alarm = 1'b0;
      end

      next_st.power_save = sleep_req && i_power_on;

      // Waves stop in power saving; half period 0 runs as 1
      for (int w = 0; w < NUM_WAVES; w++) begin
         if (!i_wave_on[w] || st.power_save || !i_power_on) begin
            next_st.wave_cnt[w] = '0;
            next_st.wave_lvl[w] = 1'b0;
         end else if (st.tick) begin
            if (st.wave_cnt[w] + HALF_W'(1) >= half[w]) begin
               next_st.wave_cnt[w] = '0;
               next_st.wave_lvl[w] = !st.wave_lvl[w];
            end else begin
               next_st.wave_cnt[w] = st.wave_cnt[w] + HALF_W'(1);
            end
         end
      end

      // Falling edge of the key is a press
      next_st.key_prev   = pin_s[PAD_CALL];
      next_st.call_press = (pmode[PAD_CALL] == MODE_ALT) && i_earphone_in
                           && st.key_prev && !pin_s[PAD_CALL]
                           && i_power_on && !st.power_save;

      for (int i = 0; i < NUM_PADS; i++) begin
         unique case (pmode[i])
            MODE_OUT: begin
               if (i_wr_mask[i]) begin
                  next_st.out_level[i] = i_wr_level[i];
               end
               next_st.pad_oe[i]    = 1'b1;
               next_st.pad_out[i]   = next_st.out_level[i];
               next_st.pad_value[i] = next_st.out_level[i];
            end
            MODE_ALT: begin
               next_st.pad_oe[i]    = alt_drv[i];
               next_st.pad_out[i]   = alt_val[i] && alt_drv[i];
               next_st.pad_value[i] = 1'b0;
            end
            MODE_IN: begin
               next_st.pad_oe[i]    = 1'b0;
               next_st.pad_out[i]   = 1'b0;
               next_st.pad_value[i] = pin_s[i];
            end
            default: begin
               next_st.pad_oe[i]    = 1'b0;
               next_st.pad_out[i]   = 1'b0;
               next_st.pad_value[i] = pin_s[i];
            end
         endcase

         // Powered off: every pad low, alarm keeps waking the host
         if (!i_power_on && !(i == PAD_ALARM && pmode[i] == MODE_ALT)) begin
            next_st.pad_oe[i]  = 1'b1;
            next_st.pad_out[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         st       <= '0;
         st.alarm <= ALARM_RST;
      end else begin
         st <= next_st;
      end
   end

   assign o_pad_out    = st.pad_out;
   assign o_pad_oe     = st.pad_oe;
   assign o_pad_value  = st.pad_value;
   assign o_power_save = st.power_save;
   assign o_call_press = st.call_press;

   property p_reset_input;
      @(posedge i_clk) $rose(i_rst_b) |-> (o_pad_oe == '0);
   endproperty
   a_reset_input: assert property (p_reset_input)
      else $error("Pads not all inputs after reset");

   property p_off_low;
      @(posedge i_clk) disable iff (!i_rst_b)
      !i_power_on |=> o_pad_oe[PAD_MUTE] && !o_pad_out[PAD_MUTE];
   endproperty
   a_off_low: assert property (p_off_low)
      else $error("Pad not driven low while powered off");

   property p_out_write;
      @(posedge i_clk) disable iff (!i_rst_b)
      (pmode[0] == MODE_OUT && i_power_on && i_wr_mask[0])
      |=> o_pad_oe[0] && o_pad_out[0] == $past(i_wr_level[0])
          && o_pad_value[0] == $past(i_wr_level[0]);
   endproperty
   a_out_write: assert property (p_out_write)
      else $error("Output write not driven or read back");

   property p_in_read;
      @(posedge i_clk) disable iff (!i_rst_b)
      (pmode[0] == MODE_IN && i_power_on)
      |=> !o_pad_oe[0] && o_pad_value[0] == $past(pin_s[0]);
   endproperty
   a_in_read: assert property (p_in_read)
      else $error("Input pad read does not match pad level");

   property p_alt_ignore;
      @(posedge i_clk) disable iff (!i_rst_b)
      (pmode[PAD_MUTE] == MODE_ALT && i_wr_mask[PAD_MUTE])
      |=> !o_pad_value[PAD_MUTE] && $stable(st.out_level[PAD_MUTE]);
   endproperty
   a_alt_ignore: assert property (p_alt_ignore)
      else $error("Alternate pad reacted to host access");

   property p_tx_follow;
      @(posedge i_clk) disable iff (!i_rst_b)
      (pmode[PAD_TX] == MODE_ALT && i_power_on)
      |=> o_pad_out[PAD_TX] == $past(i_radio_tx);
   endproperty
   a_tx_follow: assert property (p_tx_follow)
      else $error("Transmit pad does not follow radio state");

   property p_alarm_hold;
      @(posedge i_clk) disable iff (!i_rst_b)
      i_alarm_start ##1 (!i_alarm_clear [*3]) |=> st.alarm;
   endproperty
   a_alarm_hold: assert property (p_alarm_hold)
      else $error("Alarm dropped without a clear");

   property p_sleep_enter;
      @(posedge i_clk) disable iff (!i_rst_b)
      (!rx_s && i_power_on) |=> o_power_save;
   endproperty
   a_sleep_enter: assert property (p_sleep_enter)
      else $error("Receive low did not enter power saving");

   property p_call_key;
      @(posedge i_clk) disable iff (!i_rst_b)
      o_call_press |-> $past(i_earphone_in) && !$past(pin_s[PAD_CALL]);
   endproperty
   a_call_key: assert property (p_call_key)
      else $error("Call press without earphone or key press");

   property p_boot_pad;
      @(posedge i_clk) disable iff (!i_rst_b)
      (pmode[PAD_BOOT] == MODE_ALT && i_power_on)
      |=> o_pad_out[PAD_BOOT] == $past(i_boot_done);
   endproperty
   a_boot_pad: assert property (p_boot_pad)
      else $error("Active pad does not follow boot done");

   property p_wave_tick;
      @(posedge i_clk) disable iff (!i_rst_b)
      (st.wave_lvl[WAVE_TONE] != $past(st.wave_lvl[WAVE_TONE]))
      && $past(st.wave_lvl[WAVE_TONE] == 1'b0)
      |-> $past(st.tick);
   endproperty
   a_wave_tick: assert property (p_wave_tick)
      else $error("Tone edge away from a tick");

   c_call: cover property (@(posedge i_clk) o_call_press);
   c_sleep: cover property (@(posedge i_clk) $rose(o_power_save));
   c_tone: cover property (@(posedge i_clk) $rose(st.wave_lvl[WAVE_TONE]));
   c_alarm: cover property (@(posedge i_clk) $fell(st.alarm));
endmodule

// ===== rtl/pin_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module pin_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_rst_b,
   // Asynchronous inputs and settled result
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_stable
);
   import gpio_pkg::*;

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] stable;
   } sync_t;

   sync_t st;
   sync_t next_st;

   // First stage is read only by the second, against metastability
   always_comb begin
      next_st    = st;
      next_st.s1 = i_async;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      for (int i = 0; i < W; i++) begin
         if (st.s2[i] == st.s3[i]) begin
            next_st.stable[i] = st.s3[i];
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         st <= {(4 * W){SYNC_IDLE}};
      end else begin
         st <= next_st;
      end
   end

   assign o_stable = st.stable;
endmodule

// ===== shared/gpio_pkg.sv
// Shared constants, pad map and mode encoding for the pad bank
package gpio_pkg;
   // Pad count and mode selection
   localparam int          NUM_PADS_DEF = 22;
   localparam int          MODE_W       = 2;
   typedef enum logic [MODE_W-1:0] {
      MODE_IN  = 2'h0,
      MODE_OUT = 2'h1,
      MODE_ALT = 2'h2
   } mode_t;

   // Pad positions (zero based) of the pads with alternate functions
   localparam int          PAD_MUTE     = 2;
   localparam int          PAD_AMP      = 3;
   localparam int          PAD_TX       = 4;
   localparam int          PAD_ALARM    = 5;
   localparam int          PAD_TONE     = 6;
   localparam int          PAD_SLEEP    = 7;
   localparam int          PAD_VIBE     = 10;
   localparam int          PAD_CALL     = 11;
   localparam int          PAD_BOOT     = 12;
   localparam int          PAD_MIN      = 13;

   // Square wave timing: one tick per TICK_NS, half period in ticks
   localparam int          CLK_NS       = 40;
   localparam int          TICK_NS      = 100000;
   localparam int          TICK_CYCLES  = (TICK_NS + CLK_NS - 1) / CLK_NS;
   localparam int          TICK_W       = 12;
   localparam int          HALF_W       = 8;
   localparam int          NUM_WAVES    = 2;
   localparam int          WAVE_TONE    = 0;
   localparam int          WAVE_VIBE    = 1;

   // Reset values
   localparam logic        SYNC_IDLE    = 1'b1;
   localparam logic        ALARM_RST    = 1'b0;
endpackage

// ===== verif/gpio_pad_bank_tb.sv
// Self-checking bench for the pad bank
`timescale 1ns/1ns
module gpio_pad_bank_tb;
   import gpio_pkg::*;
   localparam int N = NUM_PADS_DEF;
   logic                clk;
   logic                rst_b;
   logic [MODE_W*N-1:0] mode;
   logic [N-1:0]        wr_mask;
   logic [N-1:0]        wr_level;
   logic [N-1:0]        value;
   logic [N-1:0]        pad_wire;
   logic [N-1:0]        pad_out;
   logic [N-1:0]        pad_oe;
   logic [N-1:0]        host_level;
   logic                power_on;
   logic                boot_done;
   logic                audio;
   logic                voice;
   logic                radio_tx;
   logic                earphone;
   logic                alarm_start;
   logic                alarm_clear;
   logic [1:0]          wave_on;
   logic [HALF_W-1:0]   tone_half;
   logic [HALF_W-1:0]   vibe_half;
   logic                uart_rx;
   logic                power_save;
   logic                call_press;
   logic                sleep_req_b;
   logic                call_key_b;
   logic [N-1:0]        exp_v;
   int                  failures;
   int                  checked;
   int                  n;

   gpio_pad_bank #(.NUM_PADS(N)) i_dut (
      .i_clk(clk), .i_rst_b(rst_b), .i_pad_mode(mode),
      .i_wr_mask(wr_mask), .i_wr_level(wr_level), .o_pad_value(value),
      .i_pad_in(pad_wire), .o_pad_out(pad_out), .o_pad_oe(pad_oe),
      .i_power_on(power_on), .i_boot_done(boot_done),
      .i_audio_active(audio), .i_voice_present(voice),
      .i_radio_tx(radio_tx), .i_earphone_in(earphone),
      .i_alarm_start(alarm_start), .i_alarm_clear(alarm_clear),
      .i_wave_on(wave_on), .i_tone_half(tone_half),
      .i_vibe_half(vibe_half), .i_uart_rx(uart_rx),
      .o_power_save(power_save), .o_call_press(call_press));

   host_pads #(.N(N)) i_host (
      .i_dut_out(pad_out), .i_dut_oe(pad_oe), .i_host_level(host_level),
      .i_sleep_req_b(sleep_req_b), .i_call_key_b(call_key_b),
      .o_pad_wire(pad_wire));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic step(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask

   task automatic check_vec(input logic [N-1:0] got, input logic [N-1:0] exp,
                            input string what);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp,
                            input string what);
      check_vec({{(N-1){1'b0}}, got}, {{(N-1){1'b0}}, exp}, what);
   endtask

   task automatic check_cnt(input int got, input int exp, input string what);
      checked++;
      if (got != exp) begin
         failures++;
         $display("FAIL %0t %s got %0d exp %0d", $time, what, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic write_pad(input int p, input logic lvl);
      wr_mask[p]  = 1'b1;
      wr_level[p] = lvl;
      step(1);
      wr_mask[p]  = 1'b0;
      step(1);
   endtask

   // Bounded wait for a toggle, then cycles until the next one
   task automatic wave_gap(input int p, output int gap);
      logic last;
      int   k;
      last = pad_out[p];
      k = 0;
      while (pad_out[p] === last && k < 6000) begin
         step(1);
         k++;
      end
      last = pad_out[p];
      gap = 0;
      while (pad_out[p] === last && gap < 6000) begin
         step(1);
         gap++;
      end
      if (k >= 6000 || gap >= 6000) begin
         failures++;
         $display("FAIL %0t wave pad %0d stuck", $time, p);
         tally_and_finish();
      end
   endtask

   task automatic count_press(output int c);
      c = 0;
      repeat (10) begin
         step(1);
         if (call_press === 1'b1)
            c++;
      end
   endtask

   initial begin
      failures = 0; checked = 0;
      rst_b = 1'b0; mode = '0; wr_mask = '0; wr_level = '0;
      host_level = 22'h155555; power_on = 1'b1; boot_done = 1'b0;
      audio = 1'b1; voice = 1'b1; radio_tx = 1'b1; earphone = 1'b0;
      alarm_start = 1'b0; alarm_clear = 1'b0; wave_on = 2'h0;
      tone_half = 8'h01; vibe_half = 8'h02; uart_rx = 1'b1;
      sleep_req_b = 1'b1; call_key_b = 1'b1;
      repeat (10) @(posedge clk);
      #1 rst_b = 1'b1;
      check_vec(pad_oe, '0, "oe after reset");
      check_vec(pad_out, '0, "out after reset");
      step(5);
      exp_v = host_level;
      exp_v[PAD_SLEEP] = 1'b1;
      exp_v[PAD_CALL]  = 1'b1;
      check_vec(value, exp_v, "input read");
      $display("test reset_input done");

      mode[1:0] = MODE_OUT;
      write_pad(0, 1'b1);
      check_bit(pad_oe[0], 1'b1, "out oe");
      check_bit(pad_out[0], 1'b1, "out high");
      check_bit(value[0], 1'b1, "out query");
      write_pad(0, 1'b0);
      check_bit(pad_oe[0], 1'b1, "drive low");
      check_bit(pad_out[0], 1'b0, "out low");
      write_pad(8, 1'b0);
      check_bit(value[8], 1'b1, "input ignores write");
      write_pad(8, 1'b1);
      mode[17:16] = MODE_OUT;
      mode[19:18] = 2'h3;
      host_level[9] = 1'b1;
      step(1);
      check_bit(pad_out[8], 1'b0, "kept level");
      write_pad(0, 1'b1);
      $display("test output done");

      for (int p = 2; p <= PAD_BOOT; p++) begin
         if (p != 8 && p != 9)
            mode[MODE_W*p +: MODE_W] = MODE_ALT;
      end
      step(1);
      check_bit(pad_out[PAD_MUTE], 1'b0, "mute off");
      check_bit(pad_out[PAD_AMP], 1'b1, "amp on");
      check_bit(pad_out[PAD_TX], 1'b1, "tx on");
      check_bit(pad_out[PAD_BOOT], 1'b0, "not booted");
      check_bit(pad_oe[PAD_MUTE], 1'b1, "alt drives");
      check_bit(value[PAD_TX], 1'b0, "alt read");
      write_pad(PAD_MUTE, 1'b1);
      check_bit(pad_out[PAD_MUTE], 1'b0, "alt write");
      audio = 1'b0; voice = 1'b0; radio_tx = 1'b0; boot_done = 1'b1;
      step(1);
      check_bit(pad_out[PAD_MUTE], 1'b1, "mute on");
      check_bit(pad_out[PAD_AMP], 1'b0, "amp off");
      check_bit(pad_out[PAD_TX], 1'b0, "tx off");
      check_bit(pad_out[PAD_BOOT], 1'b1, "booted");
      $display("test alternate done");

      alarm_start = 1'b1;
      step(1);
      alarm_start = 1'b0;
      check_bit(pad_out[PAD_ALARM], 1'b0, "alarm early");
      step(1);
      check_bit(pad_out[PAD_ALARM], 1'b1, "alarm rise");
      step(20);
      check_bit(pad_out[PAD_ALARM], 1'b1, "alarm held");
      alarm_clear = 1'b1;
      step(1);
      alarm_clear = 1'b0;
      step(1);
      check_bit(pad_out[PAD_ALARM], 1'b0, "alarm clear");
      check_bit(value[9], 1'b1, "mode 3 reads pad");
      check_bit(pad_oe[9], 1'b0, "mode 3 no drive");
      $display("test alarm done");

      wave_on = 2'h3;
      wave_gap(PAD_TONE, n);
      check_cnt(n, TICK_CYCLES, "tone half period");
      wave_gap(PAD_VIBE, n);
      check_cnt(n, 2 * TICK_CYCLES, "vibe half period");
      $display("test waves done");

      voice = 1'b1;
      sleep_req_b = 1'b0;
      step(4);
      check_bit(power_save, 1'b0, "sync delay");
      step(1);
      check_bit(power_save, 1'b1, "sleep request");
      step(2);
      check_bit(pad_out[PAD_TONE], 1'b0, "tone off");
      check_bit(pad_out[PAD_VIBE], 1'b0, "vibe off");
      check_bit(pad_out[PAD_AMP], 1'b0, "amp off saving");
      sleep_req_b = 1'b1;
      step(6);
      check_bit(power_save, 1'b0, "wake");
      uart_rx = 1'b0;
      step(5);
      check_bit(power_save, 1'b1, "rx low saving");
      uart_rx = 1'b1;
      wave_on = 2'h0;
      step(6);
      $display("test power_save done");

      call_key_b = 1'b0;
      count_press(n);
      check_cnt(n, 0, "press no earphone");
      call_key_b = 1'b1;
      earphone = 1'b1;
      step(6);
      call_key_b = 1'b0;
      count_press(n);
      check_cnt(n, 1, "press earphone");
      call_key_b = 1'b1;
      $display("test call_key done");

      alarm_start = 1'b1;
      step(1);
      alarm_start = 1'b0;
      step(2);
      power_on = 1'b0;
      step(1);
      exp_v = '0;
      exp_v[PAD_ALARM] = 1'b1;
      check_vec(pad_out, exp_v, "powered off pads");
      check_vec(pad_oe, '1, "powered off drive");
      check_bit(pad_out[PAD_BOOT], 1'b0, "active off");
      $display("test power_off done");
      tally_and_finish();
   end
endmodule

// ===== verif/host_pads.sv
// Host side model of the pads: resolves each pad wire
`timescale 1ns/1ns
module host_pads #(
   parameter int N = 22
) (
   // Design pad drive
   input  wire logic [N-1:0] i_dut_out,
   input  wire logic [N-1:0] i_dut_oe,
   // Host drive
   input  wire logic [N-1:0] i_host_level,
   input  wire logic         i_sleep_req_b,
   input  wire logic         i_call_key_b,
   // Resolved pad levels
   output logic      [N-1:0] o_pad_wire
);
   import gpio_pkg::*;
   logic [N-1:0] host_drive;
   always_comb begin
      host_drive = i_host_level;
      host_drive[PAD_SLEEP] = i_sleep_req_b;
      host_drive[PAD_CALL]  = i_call_key_b;
      for (int i = 0; i < N; i++) begin
         // Host buffer yields wherever the design drives
         o_pad_wire[i] = i_dut_oe[i] ? i_dut_out[i] : host_drive[i];
      end
   end
endmodule
